// >>> verilog/keyboard_host_port_runtime.v
/*
  Runtime register port of an emulated keyboard controller: host I/O side
  at a programmed base, firmware side at a fixed internal address.
  Assumes host and firmware strobes are one-cycle pulses on clk_sys, and
  that the LPC reset pin arrives asynchronously.
  Host and firmware sides share the one clock; only the LPC reset pin
  crosses in, through two flops, before any logic reads it.
*/
// Operation
// R1: Host data write latches byte, tag 0, full
// R2: Host command write latches byte, tag 1, full
// R3: Host read offset 0 returns output byte
// R4: Host read offset 4 returns status byte
// R5: Host output read clears full and irqs; code clears only host_output_full_irq_ff and raises output_emptied_irq_ff
// R6: Host status view is read-only mirror
// R7: User bits written only by firmware alias
// R8: Aux flag set by aux write, cleared by data
// R9: Status bit 3 shows command/data tag
// R10: User bit low cleared by LPC reset
// R11: Input full raises firmware irq if enabled
// R12: Firmware read of input clears full and irq
// R13: Input full survives power-good, LPC power-down
// R14: Output full set on data or aux write
// R15: Host output read raises emptied irq
// R16: Output full cleared only by host read
// R17: Host I/O base programmable; firmware fixed base
// R18: Firmware input alias returns last host byte
// R19: Single byte per direction; new write overwrites
`timescale 1ns/1ps
`include "kbd_port_defs.vh"

module keyboard_host_port_runtime (
  input wire clk_sys,
  input wire rst_n,
  input wire lreset_n,
  input wire [15:0] host_base,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_addr,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata_ff,
  output reg host_ack_ff,
  input wire fw_wr,
  input wire fw_rd,
  input wire [31:0] fw_addr,
  input wire [7:0] fw_wdata,
  output reg [7:0] fw_rdata_ff,
  output reg fw_ack_ff,
  output reg fw_err_ff,
  input wire input_full_irq_en,
  input wire fw_in_ready,
  output reg fw_in_valid_ff,
  output reg [7:0] fw_in_byte_ff,
  output reg input_full_irq_ff,
  output reg output_emptied_irq_ff,
  output reg host_output_full_irq_ff,
  output reg [7:0] status_ff
);

  // ========================================================================
  // Address decode helpers
  function host_hit;
    input [15:0] addr;
    input [15:0] base;
    input [2:0] ofs;
    begin
      host_hit = (addr == (base + {13'h0000, ofs}));
    end
  endfunction

  function fw_hit;
    input [31:0] addr;
    input [31:0] base;
    input [7:0] ofs;
    begin
      fw_hit = (addr == (base + {24'h000000, ofs}));
    end
  endfunction

  // ========================================================================
  // LPC reset synchroniser
  reg lrst_meta_ff;
  reg lrst_sync_ff;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      lrst_meta_ff <= 1'b0;
      lrst_sync_ff <= 1'b0;
    end else begin
      lrst_meta_ff <= lreset_n;
      lrst_sync_ff <= lrst_meta_ff;
    end
  end

  wire lpc_in_reset = !lrst_sync_ff;

  // ========================================================================
  // Decode
  wire h_wr_data = host_wr && host_hit(host_addr, host_base, `RT_DATA_OFS); // [R17]
  wire h_wr_cmd = host_wr && host_hit(host_addr, host_base, `RT_CMD_STAT_OFS);
  wire h_rd_data = host_rd && host_hit(host_addr, host_base, `RT_DATA_OFS);
  wire h_rd_stat = host_rd && host_hit(host_addr, host_base, `RT_CMD_STAT_OFS);

  wire f_wr_data = fw_wr && fw_hit(fw_addr, `FW_ALIAS_BASE, `FW_DATA_OFS);
  wire f_wr_aux = fw_wr && fw_hit(fw_addr, `FW_ALIAS_BASE, `FW_AUX_OFS);
  wire f_wr_stat = fw_wr && fw_hit(fw_addr, `FW_ALIAS_BASE, `FW_STAT_OFS);
  wire f_rd_data = fw_rd && fw_hit(fw_addr, `FW_ALIAS_BASE, `FW_DATA_OFS);
  wire f_rd_stat = fw_rd && fw_hit(fw_addr, `FW_ALIAS_BASE, `FW_STAT_OFS);
  wire f_rd_rt_data = fw_rd && fw_hit(fw_addr, `FW_RT_BASE, `FW_DATA_OFS);
  wire f_rd_rt_stat = fw_rd && fw_hit(fw_addr, `FW_RT_BASE, `FW_STAT_OFS);
  wire f_any_hit = f_wr_data || f_wr_aux || f_wr_stat || f_rd_data || f_rd_stat
                   || f_rd_rt_data || f_rd_rt_stat;

  // ========================================================================
  // Byte holders and flags
  reg [7:0] in_byte_ff;
  reg [7:0] out_byte_ff;
  reg cmd_tag_ff;
  reg in_full_ff;
  reg out_full_ff;
  reg aux_full_ff;
  reg user_low_ff;
  reg user_mid_ff;
  reg [1:0] user_hi_ff;

  // Host write wins over a same-cycle firmware read so no byte goes missing
  wire in_set = h_wr_data || h_wr_cmd;
  wire in_clr = f_rd_data || f_rd_rt_data;
  wire out_set = f_wr_data || f_wr_aux;

  // ========================================================================
  // Next values of the byte holders and flags
  reg [7:0] nxt_in_byte;
  reg [7:0] nxt_out_byte;
  reg nxt_cmd_tag;
  reg nxt_in_full;
  reg nxt_out_full;
  reg nxt_aux_full;
  reg nxt_user_mid;
  reg [1:0] nxt_user_hi;

  always @* begin
    nxt_in_byte = in_byte_ff;
    nxt_out_byte = out_byte_ff;
    nxt_cmd_tag = cmd_tag_ff;
    nxt_in_full = in_full_ff;
    nxt_out_full = out_full_ff;
    nxt_aux_full = aux_full_ff;
    nxt_user_mid = user_mid_ff;
    nxt_user_hi = user_hi_ff;
    if (h_wr_data) begin
      nxt_in_byte = host_wdata; // [R1] [R19]
      nxt_cmd_tag = 1'b0; // [R9]
    end else if (h_wr_cmd) begin
      nxt_in_byte = host_wdata; // [R2] [R19]
      nxt_cmd_tag = 1'b1; // [R9]
    end
    // Power-good and LPC power-down do not touch these flags
    if (in_set) begin
      nxt_in_full = 1'b1; // [R11] [R13]
    end else if (in_clr) begin
      nxt_in_full = 1'b0; // [R12]
    end
    // Firmware refill wins over a same-cycle host drain
    if (out_set) begin
      nxt_out_full = 1'b1; // [R14]
    end else if (h_rd_data) begin
      nxt_out_full = 1'b0; // [R5] [R16]
    end
    if (f_wr_aux) begin
      nxt_aux_full = 1'b1; // [R8]
    end else if (f_wr_data) begin
      nxt_aux_full = 1'b0; // [R8]
    end
    if (out_set) begin
      nxt_out_byte = fw_wdata; // [R19]
    end
    if (f_wr_stat) begin
      nxt_user_mid = fw_wdata[`ST_USER_MID]; // [R7]
      nxt_user_hi = fw_wdata[`ST_USER_HI_MSB:`ST_USER_HI_LSB]; // [R7]
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      in_byte_ff <= `BYTE_RST;
      out_byte_ff <= `BYTE_RST;
      cmd_tag_ff <= 1'b0;
      in_full_ff <= 1'b0;
      out_full_ff <= 1'b0;
      aux_full_ff <= 1'b0;
      user_mid_ff <= 1'b0;
      user_hi_ff <= 2'b00;
    end else begin
      in_byte_ff <= nxt_in_byte;
      out_byte_ff <= nxt_out_byte;
      cmd_tag_ff <= nxt_cmd_tag;
      in_full_ff <= nxt_in_full;
      out_full_ff <= nxt_out_full;
      aux_full_ff <= nxt_aux_full;
      user_mid_ff <= nxt_user_mid;
      user_hi_ff <= nxt_user_hi;
    end
  end

  // Separate process: this bit alone also falls to the LPC reset
  always @(posedge clk_sys) begin
    if (!rst_n || lpc_in_reset)
      user_low_ff <= 1'b0; // [R10]
    else if (f_wr_stat)
      user_low_ff <= fw_wdata[`ST_USER_LOW]; // [R7]
  end

  wire [7:0] status_now = {user_hi_ff, aux_full_ff, user_mid_ff, cmd_tag_ff,
                           user_low_ff, in_full_ff, out_full_ff};

  // ========================================================================
  // Interrupts toward firmware and host
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      input_full_irq_ff <= 1'b0;
      output_emptied_irq_ff <= 1'b0;
      host_output_full_irq_ff <= 1'b0;
    end else begin
      input_full_irq_ff <= nxt_in_full && input_full_irq_en; // [R11] [R12]
      output_emptied_irq_ff <= h_rd_data && out_full_ff; // [R15]
      if (out_set) begin
        host_output_full_irq_ff <= 1'b1;
      end else if (h_rd_data) begin
        host_output_full_irq_ff <= 1'b0; // [R5]
      end
    end
  end

  // ========================================================================
  // Host read path
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      host_rdata_ff <= `BYTE_RST;
      host_ack_ff <= 1'b0;
    end else begin
      host_ack_ff <= h_wr_data || h_wr_cmd || h_rd_data || h_rd_stat;
      if (h_rd_data) begin
        host_rdata_ff <= out_byte_ff; // [R3]
      end else if (h_rd_stat) begin
        host_rdata_ff <= status_now; // [R4] [R6]
      end
    end
  end

  // ========================================================================
  // Firmware read path
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fw_rdata_ff <= `BYTE_RST;
      fw_ack_ff <= 1'b0;
      fw_err_ff <= 1'b0;
    end else begin
      fw_ack_ff <= (fw_wr || fw_rd) && f_any_hit;
      fw_err_ff <= (fw_wr || fw_rd) && !f_any_hit;
      if (f_rd_data || f_rd_rt_data) begin
        fw_rdata_ff <= in_byte_ff; // [R18]
      end else if (f_rd_stat || f_rd_rt_stat) begin
        fw_rdata_ff <= status_now;
      end else if (fw_rd) begin
        // Unmapped reads return zero so stale bytes never leak
        fw_rdata_ff <= `BYTE_RST;
      end
    end
  end

  // ========================================================================
  // Two-entry buffer carrying host bytes to a firmware stream consumer;
  // a stalled consumer keeps both entries, excess bytes beyond two are dropped
  reg [7:0] buf_mem [0:1];
  reg buf_wp_ff;
  reg buf_rp_ff;
  reg [1:0] buf_cnt_ff;
  reg nxt_buf_wp;
  reg nxt_buf_rp;
  reg [1:0] nxt_buf_cnt;
  reg [7:0] nxt_fw_in_byte;
  wire buf_push = in_set && (buf_cnt_ff != 2'd2);
  wire buf_pop = fw_in_valid_ff && fw_in_ready;

  // Head byte is looked up a cycle ahead so the stream output stays a flop
  always @* begin
    nxt_buf_wp = buf_wp_ff;
    nxt_buf_rp = buf_rp_ff;
    nxt_buf_cnt = buf_cnt_ff;
    if (buf_push) begin
      nxt_buf_wp = !buf_wp_ff;
    end
    if (buf_pop) begin
      nxt_buf_rp = !buf_rp_ff;
    end
    if (buf_push && !buf_pop) begin
      nxt_buf_cnt = buf_cnt_ff + 2'd1;
    end else if (buf_pop && !buf_push) begin
      nxt_buf_cnt = buf_cnt_ff - 2'd1;
    end
    // Empty, or draining its last entry: the incoming byte goes straight out
    if (buf_cnt_ff == 2'd0 || (buf_cnt_ff == 2'd1 && buf_pop)) begin
      nxt_fw_in_byte = host_wdata;
    end else begin
      nxt_fw_in_byte = buf_mem[nxt_buf_rp];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
      buf_cnt_ff <= 2'd0;
      buf_mem[0] <= `BYTE_RST;
      buf_mem[1] <= `BYTE_RST;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp_ff] <= host_wdata;
      end
      buf_wp_ff <= nxt_buf_wp;
      buf_rp_ff <= nxt_buf_rp;
      buf_cnt_ff <= nxt_buf_cnt;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fw_in_valid_ff <= 1'b0;
      fw_in_byte_ff <= `BYTE_RST;
      status_ff <= `BYTE_RST;
    end else begin
      fw_in_valid_ff <= (nxt_buf_cnt != 2'd0);
      fw_in_byte_ff <= nxt_fw_in_byte;
      status_ff <= status_now;
    end
  end

endmodule

// >>> include/kbd_port_defs.vh
/*
  Constants for the keyboard host port: runtime offsets, firmware alias
  offsets, status field positions and reset values.
  Assumes inclusion by bare name from the design file.
*/
`ifndef KBD_PORT_DEFS_VH
`define KBD_PORT_DEFS_VH

// ==========================================================================
// Host runtime offsets (I/O, relative to programmed base)
`define RT_DATA_OFS 3'h0
`define RT_CMD_STAT_OFS 3'h4

// ==========================================================================
// Firmware internal addresses
`define FW_RT_BASE 32'h400f0400
`define FW_ALIAS_BASE 32'h400f0410
`define FW_DATA_OFS 8'h00
`define FW_STAT_OFS 8'h04
`define FW_AUX_OFS 8'h0c

// ==========================================================================
// Status byte fields
`define ST_OUT_FULL 0
`define ST_IN_FULL 1
`define ST_USER_LOW 2
`define ST_CMD_TAG 3
`define ST_USER_MID 4
`define ST_AUX_FULL 5
`define ST_USER_HI_LSB 6
`define ST_USER_HI_MSB 7

`define BYTE_RST 8'h00
`define HOST_BASE_RST 16'h0060

`endif

// >>> tb/kbd_port_chk_sva.sv
/* Checker for the keyboard host port, bound to the port's top module.
   Assumes status_ff trails the internal flags by one cycle. */
`timescale 1ns/1ps
module kbd_port_chk (
  input logic clk_sys,
  input logic rst_n,
  input logic lreset_n,
  input logic [15:0] host_base,
  input logic host_wr,
  input logic host_rd,
  input logic [15:0] host_addr,
  input logic fw_wr,
  input logic fw_rd,
  input logic [31:0] fw_addr,
  input logic fw_err_ff,
  input logic fw_in_ready,
  input logic fw_in_valid_ff,
  input logic output_emptied_irq_ff,
  input logic host_output_full_irq_ff,
  input logic [7:0] status_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  wire dat_hit = host_addr == host_base;
  wire cmd_hit = host_addr == host_base + 16'h4;
  AST_DATA_WR: assert property (host_wr && dat_hit |-> ##2 status_ff[1] && !status_ff[3])
    else $error("data write flags wrong");
  AST_CMD_WR: assert property (host_wr && cmd_hit |-> ##2 status_ff[1] && status_ff[3])
    else $error("command write flags wrong");
  // Bits 3 to 1 masked: lreset sync and the write itself may move them
  AST_STAT_RO: assert property (host_wr && cmd_hit && !fw_wr && !fw_rd |-> ##2 (status_ff & 8'hf1) == ($past(status_ff) & 8'hf1))
    else $error("host write altered status");
  AST_OUT_CLR: assert property (host_rd && dat_hit && !fw_wr |-> ##2 !status_ff[0])
    else $error("output full not cleared");
  AST_EMPTY_IRQ: assert property (output_emptied_irq_ff |-> $past(host_rd) && $past(dat_hit))
    else $error("emptied irq without host read");
  AST_HIRQ_CLR: assert property (host_rd && dat_hit && !fw_wr |=> !host_output_full_irq_ff)
    else $error("host irq not cleared");
  AST_AUX_WR: assert property (fw_wr && fw_addr == 32'h400f041c |=> host_output_full_irq_ff ##1 status_ff[0] && status_ff[5])
    else $error("aux write flags wrong");
  AST_DAT_OUT: assert property (fw_wr && fw_addr == 32'h400f0410 |-> ##2 status_ff[0] && !status_ff[5])
    else $error("data out flags wrong");
  AST_IN_CLR: assert property (fw_rd && fw_addr == 32'h400f0410 && !host_wr |-> ##2 !status_ff[1])
    else $error("input full not cleared");
  AST_LRST: assert property (!lreset_n [*6] |-> !status_ff[2])
    else $error("user bit low survives bus reset");
  cover property (output_emptied_irq_ff);
  cover property (fw_err_ff);
  cover property (fw_in_valid_ff && !fw_in_ready);
endmodule
bind keyboard_host_port_runtime kbd_port_chk u_kbd_port_chk (.*);

// >>> tb/lpc_host_model.sv
/* Host bus model: one-byte I/O reads and writes at a base.
   Assumes the port acks one cycle after the strobe edge. */
`timescale 1ns/1ps
module lpc_host_model #(parameter logic [15:0] BASE = 16'h0060) (
  input logic clk_sys,
  input logic host_ack_ff,
  input logic [7:0] host_rdata_ff,
  output logic host_wr = 1'b0,
  output logic host_rd = 1'b0,
  output logic [15:0] host_addr = 16'h0000,
  output logic [7:0] host_wdata = 8'h00
);
  // ==========================================================================
  // Access task; no ack leaves q unknown so the caller's compare fails
  task automatic acc(input logic w, input logic [2:0] o, input logic [7:0] d, output logic [7:0] q);
    q = 8'hxx;
    @(posedge clk_sys);
    host_wr <= w;
    host_rd <= !w;
    host_addr <= BASE + o;
    host_wdata <= d;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    repeat (4) begin
      @(posedge clk_sys);
      if (host_ack_ff) begin
        q = host_rdata_ff;
        break;
      end
    end
    // Released lines show garbage, not the last value
    host_addr <= ~host_addr;
    host_wdata <= ~host_wdata;
  endtask
endmodule

// >>> tb/keyboard_host_port_runtime_bench.sv
/* Bench for the keyboard host port: host and firmware accesses,
   status checks and a stalled input stream. Assumes the bound checker. */
`timescale 1ns/1ps
module keyboard_host_port_runtime_bench;
  localparam logic [15:0] BASE = 16'h0060;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic lreset_n = 1'b1;
  logic fw_wr = 1'b0;
  logic fw_rd = 1'b0;
  logic [31:0] fw_addr = 32'h0;
  logic [7:0] fw_wdata = 8'h00;
  logic input_full_irq_en = 1'b1;
  logic fw_in_ready = 1'b1;
  wire host_wr, host_rd, host_ack_ff, fw_ack_ff, fw_err_ff, fw_in_valid_ff;
  wire input_full_irq_ff, output_emptied_irq_ff, host_output_full_irq_ff;
  wire [15:0] host_addr;
  wire [7:0] host_wdata, host_rdata_ff, fw_rdata_ff, fw_in_byte_ff, status_ff;
  logic [7:0] q;
  logic ferr;
  logic [7:0] got[$];
  int error_cnt = 0;
  int n_checks = 0;
  int n_empty = 0;
  always #5 clk_sys = ~clk_sys;
  keyboard_host_port_runtime u_keyboard_host_port_runtime (.host_base(BASE), .*);
  lpc_host_model #(.BASE(BASE)) u_lpc_host_model (.*);
  always @(posedge clk_sys) if (fw_in_valid_ff && fw_in_ready) got.push_back(fw_in_byte_ff);
  always @(posedge clk_sys) if (output_emptied_irq_ff === 1'b1) n_empty++;
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic st(input logic [7:0] e);
    u_lpc_host_model.acc(1'b0, 3'h4, 8'h00, q);
    chk(q, e);
  endtask
  task automatic fw(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    fw_wr <= w;
    fw_rd <= !w;
    fw_addr <= a;
    fw_wdata <= d;
    @(posedge clk_sys);
    fw_wr <= 1'b0;
    fw_rd <= 1'b0;
    q = 8'hxx;
    ferr = 1'bx;
    repeat (4) begin
      @(posedge clk_sys);
      if (fw_ack_ff || fw_err_ff) begin
        q = fw_rdata_ff;
        ferr = fw_err_ff;
        break;
      end
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    #20000;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    st(8'h00);
    fw(1'b0, 32'h400f0404, 8'h00);
    chk(q, 8'h00);
    u_lpc_host_model.acc(1'b1, 3'h0, 8'h11, q);
    st(8'h02);
    chk({7'h00, input_full_irq_ff}, 8'h01);
    input_full_irq_en <= 1'b0;
    u_lpc_host_model.acc(1'b1, 3'h4, 8'h22, q);
    st(8'h0a);
    chk({7'h00, input_full_irq_ff}, 8'h00);
    input_full_irq_en <= 1'b1;
    fw(1'b0, 32'h400f0410, 8'h00);
    chk(q, 8'h22);
    st(8'h08);
    chk({7'h00, input_full_irq_ff}, 8'h00);
    fw(1'b1, 32'h400f0414, 8'hff);
    st(8'hdc);
    lreset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    lreset_n <= 1'b1;
    st(8'hd8);
    fw(1'b1, 32'h400f041c, 8'h5a);
    st(8'hf9);
    chk({7'h00, host_output_full_irq_ff}, 8'h01);
    fw(1'b1, 32'h400f0410, 8'h6b);
    st(8'hd9);
    u_lpc_host_model.acc(1'b0, 3'h0, 8'h00, q);
    chk(q, 8'h6b);
    st(8'hd8);
    chk(8'(n_empty), 8'h01);
    chk({7'h00, host_output_full_irq_ff}, 8'h00);
    fw(1'b0, 32'h400f0420, 8'h00);
    chk({7'h00, ferr}, 8'h01);
    // Stalled consumer: two words fit, the third is dropped
    fw_in_ready <= 1'b0;
    got.delete();
    for (int i = 0; i < 3; i++) u_lpc_host_model.acc(1'b1, 3'h0, 8'ha1 + i[7:0], q);
    fw_in_ready <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(8'(got.size()), 8'h02);
    chk(got[0], 8'ha1);
    chk(got[1], 8'ha2);
    stop_test;
  end
endmodule
